/* File: dsbs_pkg.sv */
// Shared constants of the drive source and brake block.
package dsbs_pkg;
    // Clock and brake timebase.
    localparam int CLK_HZ       = 20_000_000;
    localparam int TICK_MS      = 10;
    localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    // Bus geometry.
    localparam int ADDR_W       = 7;
    localparam int REG_COUNT    = 16;
    // Register indices; byte address is four times the index.
    localparam logic [3:0] REG_SRC     = 4'h0;
    localparam logic [3:0] REG_PROT    = 4'h1;
    localparam logic [3:0] REG_CTRL    = 4'h2;
    localparam logic [3:0] REG_CUR     = 4'h3;
    localparam logic [3:0] REG_DLY     = 4'h4;
    localparam logic [3:0] REG_FRQ     = 4'h5;
    localparam logic [3:0] REG_ENG     = 4'h6;
    localparam logic [3:0] REG_STATUS  = 4'h7;
    localparam logic [3:0] REG_INFUNC0 = 4'h8;
    // Writable bit masks per register.
    localparam logic [31:0] MASK_SRC    = 32'h0000_f373;
    localparam logic [31:0] MASK_PROT   = 32'h0000_0173;
    localparam logic [31:0] MASK_CTRL   = 32'h001f_1f03;
    localparam logic [31:0] MASK_CUR    = 32'h0000_07ff;
    localparam logic [31:0] MASK_DLY    = 32'h03ff_03ff;
    localparam logic [31:0] MASK_FRQ    = 32'hffff_ffff;
    localparam logic [31:0] MASK_ENG    = 32'h0000_ffff;
    localparam logic [31:0] MASK_INFUNC = 32'h0000_001f;
    // Reset values (frequencies 0.01 Hz, current 0.1 %, delays 0.01 s).
    localparam logic [31:0] RST_SRC     = 32'h0000_0101;
    localparam logic [31:0] RST_PROT    = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL    = 32'h0011_0c00;
    localparam logic [31:0] RST_CUR     = 32'h0000_01f4;
    localparam logic [31:0] RST_DLY     = 32'h0064_0064;
    localparam logic [31:0] RST_FRQ     = 32'h0064_0064;
    localparam logic [31:0] RST_ENG     = 32'h0000_00c8;
    localparam logic [31:0] RST_INFUNC7 = 32'h0000_0007;
    // Field positions.
    localparam int F_ALT_RUN = 0;
    localparam int F_ALT_SPD = 4;
    localparam int F_PRI_RUN = 8;
    localparam int F_PRI_SPD = 12;
    localparam int F_STOP    = 0;
    localparam int F_STALL   = 4;
    localparam int F_VLIM    = 8;
    localparam int F_OUTFUNC = 8;
    localparam int F_RLYFUNC = 16;
    localparam int F_HI      = 16;
    // Codes.
    localparam logic [4:0] FUNC_SECOND_SOURCE = 5'h16;
    localparam logic [4:0] FUNC_BRAKE_OUT     = 5'h13;
    localparam logic [1:0] STOP_POWER_BRAKE   = 2'h3;
    localparam logic [1:0] CTRL_VF            = 2'h0;
    localparam logic [1:0] RUN_KEYPAD         = 2'h0;
    localparam logic [1:0] RUN_FWD_REV        = 2'h1;
    localparam logic [1:0] RUN_RUN_DIR        = 2'h2;
    localparam logic [1:0] RUN_LINK           = 2'h3;
    localparam int STALL_ACC = 0;
    localparam int STALL_CON = 1;
    localparam int STALL_DEC = 2;
    // Brake sequencer states.
    typedef enum logic [2:0] {
        BRK_IDLE   = 3'b000,
        BRK_ACCEL  = 3'b001,
        BRK_WAITI  = 3'b010,
        BRK_RHOLD  = 3'b011,
        BRK_RUN    = 3'b100,
        BRK_DECEL  = 3'b101,
        BRK_EHOLD  = 3'b110,
        BRK_ZERO   = 3'b111
    } dsbs_brk_state_t;
endpackage

/* File: dsbs_top.sv */
// Source selection, deceleration protection choice and brake sequencer of a drive.
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module dsbs_top #(
    parameter int TICK_LEN = dsbs_pkg::TICK_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic [dsbs_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic [7:0]                  input_terminals,
    input  wire logic                        keypad_run,
    input  wire logic                        keypad_dir_ccw,
    input  wire logic                        forward_run_input,
    input  wire logic                        reverse_run_input,
    input  wire logic                        link_run,
    input  wire logic                        link_dir_ccw,
    input  wire logic [15:0]                 output_frequency,
    input  wire logic [10:0]                 motor_current,
    input  wire logic                        accelerating,
    input  wire logic                        decelerating,
    input  wire logic                        dc_link_high,
    output logic                             run_command,
    output logic                             run_dir_ccw,
    output logic [3:0]                       speed_source,
    output logic                             ramp_stop,
    output logic                             stall_accel_en,
    output logic                             stall_const_en,
    output logic                             stall_decel_en,
    output logic                             power_brake_en,
    output logic                             decel_slope_reduce,
    output logic                             brake_release,
    output logic                             freq_hold,
    output logic [15:0]                      freq_hold_value,
    output logic                             force_zero,
    output logic                             start_dc_dwell_inhibit
);
    import dsbs_pkg::*;

    // Decodes a run source into {run, direction}.
    function automatic logic [1:0] run_decode(input logic [1:0] src, input logic kr,
                                              input logic kd, input logic fx, input logic rx,
                                              input logic lr, input logic ld);
        logic [1:0] r;
        case (src)
            RUN_KEYPAD:  r = {kr, kd};
            RUN_FWD_REV: r = {fx ^ rx, rx & ~fx};
            RUN_RUN_DIR: r = {fx, rx};
            RUN_LINK:    r = {lr, ld};
            default:     r = 2'b00;
        endcase
        return r;
    endfunction

    // Merges write data under byte enables and a writable mask.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] m);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
        return (old & ~bm) | (wd & bm);
    endfunction

    logic [31:0] reg_q [REG_COUNT];
    logic [31:0] reg_d [REG_COUNT];
    logic [31:0] rdata_q, rdata_d;
    logic        wait_q, wait_d;
    logic [31:0] status_w;
    logic [3:0]  idx;
    logic        mapped, sel_on, brk_routed, brk_active, dec_bit;
    logic [1:0]  pri_rc, alt_rc, run_sel;

    assign idx        = avs_address[5:2];
    assign mapped     = (avs_address[ADDR_W-1] == 1'b0);
    assign dec_bit    = reg_q[REG_PROT][F_STALL + STALL_DEC];
    assign brk_routed = (reg_q[REG_CTRL][F_OUTFUNC +: 5] == FUNC_BRAKE_OUT) ||
                        (reg_q[REG_CTRL][F_RLYFUNC +: 5] == FUNC_BRAKE_OUT);
    assign brk_active = brk_routed && (reg_q[REG_CTRL][1:0] == CTRL_VF);

    // Selector is on when any terminal coded as second source is high.
    always_comb begin
        sel_on = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (reg_q[int'(REG_INFUNC0) + i][4:0] == FUNC_SECOND_SOURCE && input_terminals[i]) begin
                sel_on = 1'b1;
            end
        end
    end

    // Run command of each source set and the chosen one.
    assign pri_rc  = run_decode(reg_q[REG_SRC][F_PRI_RUN +: 2], keypad_run, keypad_dir_ccw,
                                forward_run_input, reverse_run_input, link_run, link_dir_ccw);
    assign alt_rc  = run_decode(reg_q[REG_SRC][F_ALT_RUN +: 2], keypad_run, keypad_dir_ccw,
                                forward_run_input, reverse_run_input, link_run,
                                link_dir_ccw);
    assign run_sel = sel_on ? alt_rc : pri_rc;

    // Bus slave: one wait cycle, then the access completes.
    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        for (int i = 0; i < REG_COUNT; i++) begin
            reg_d[i] = reg_q[i];
        end
        if ((avs_read || avs_write) && wait_q) begin
            wait_d  = 1'b0;
            rdata_d = 32'h0000_0000;
            if (avs_read && mapped) begin
                if (idx == REG_STATUS) begin
                    rdata_d = status_w;
                end else if (idx >= REG_CUR && idx <= REG_ENG && !brk_routed) begin
                    rdata_d = 32'h0000_0000;
                end else if (idx == REG_PROT && !dec_bit) begin
                    rdata_d = reg_q[idx] & ~(32'h1 << F_VLIM);
                end else begin
                    rdata_d = reg_q[idx];
                end
            end
        end
        if (avs_write && !wait_q && mapped) begin
            case (idx)
                REG_SRC:  reg_d[idx] = merge(reg_q[idx], avs_writedata, avs_byteenable, MASK_SRC);
                REG_PROT: reg_d[idx] = merge(reg_q[idx], avs_writedata, avs_byteenable,
                                             dec_bit ? MASK_PROT :
                                             (MASK_PROT & ~(32'h1 << F_VLIM)));
                REG_CTRL: reg_d[idx] = merge(reg_q[idx], avs_writedata, avs_byteenable, MASK_CTRL);
                REG_CUR:  if (brk_routed) reg_d[idx] = merge(reg_q[idx], avs_writedata,
                                                             avs_byteenable, MASK_CUR);
                REG_DLY:  if (brk_routed) reg_d[idx] = merge(reg_q[idx], avs_writedata,
                                                             avs_byteenable, MASK_DLY);
                REG_FRQ:  if (brk_routed) reg_d[idx] = merge(reg_q[idx], avs_writedata,
                                                             avs_byteenable, MASK_FRQ);
                REG_ENG:  if (brk_routed) reg_d[idx] = merge(reg_q[idx], avs_writedata,
                                                             avs_byteenable, MASK_ENG);
                REG_STATUS: reg_d[idx] = reg_q[idx];
                default:  reg_d[idx] = merge(reg_q[idx], avs_writedata, avs_byteenable,
                                             MASK_INFUNC);
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
            for (int i = 0; i < REG_COUNT; i++) begin
                reg_q[i] <= 32'h0000_0000;
            end
            reg_q[REG_SRC]  <= RST_SRC;
            reg_q[REG_PROT] <= RST_PROT;
            reg_q[REG_CTRL] <= RST_CTRL;
            reg_q[REG_CUR]  <= RST_CUR;
            reg_q[REG_DLY]  <= RST_DLY;
            reg_q[REG_FRQ]  <= RST_FRQ;
            reg_q[REG_ENG]  <= RST_ENG;
            reg_q[int'(REG_INFUNC0) + 7] <= RST_INFUNC7;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < REG_COUNT; i++) begin
                reg_q[i] <= reg_d[i];
            end
        end
    end
    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    // Source and protection outputs, all registered.
    logic       run_q, dir_q, rstop_q, sel_q, sa_q, sc_q, sd_q, pb_q, slope_q;
    logic       run_d, dir_d, rstop_d, sa_d, sc_d, sd_d, pb_d, slope_d;
    logic [3:0] spd_q, spd_d;
    logic       pb_sel;
    assign pb_sel = (reg_q[REG_PROT][F_STOP +: 2] == STOP_POWER_BRAKE);
    always_comb begin
        run_d = run_sel[1];
        dir_d = run_sel[0];
        spd_d = sel_on ? {1'b0, reg_q[REG_SRC][F_ALT_SPD +: 3]}
                       : reg_q[REG_SRC][F_PRI_SPD +: 4];
        // A run lost to a link-driven primary set ramps down.
        rstop_d = rstop_q;
        if (sel_q && !sel_on && run_q && !pri_rc[1] &&
            reg_q[REG_SRC][F_PRI_RUN +: 2] == RUN_LINK) begin
            rstop_d = 1'b1;
        end else if (run_sel[1]) begin
            rstop_d = 1'b0;
        end
        sa_d    = reg_q[REG_PROT][F_STALL + STALL_ACC] && accelerating;
        sc_d    = reg_q[REG_PROT][F_STALL + STALL_CON] && !accelerating && !decelerating;
        sd_d    = dec_bit && decelerating && !pb_sel;
        pb_d    = pb_sel && decelerating;
        slope_d = pb_sel && decelerating && dc_link_high;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {run_q, dir_q, spd_q, rstop_q, sel_q, sa_q, sc_q, sd_q, pb_q, slope_q} <= '0;
        end else begin
            {run_q, dir_q, spd_q, rstop_q, sel_q} <= {run_d, dir_d, spd_d, rstop_d, sel_on};
            {sa_q, sc_q, sd_q, pb_q, slope_q}     <= {sa_d, sc_d, sd_d, pb_d, slope_d};
        end
    end
    assign run_command        = run_q;
    assign run_dir_ccw        = dir_q;
    assign speed_source       = spd_q;
    assign ramp_stop          = rstop_q;
    assign stall_accel_en     = sa_q;
    assign stall_const_en     = sc_q;
    assign stall_decel_en     = sd_q;
    assign power_brake_en     = pb_q;
    assign decel_slope_reduce = slope_q;

    // Brake sequencer; a delay of N shared ticks lasts N to N+1 ticks.
    localparam int TW = $clog2(TICK_LEN + 1);
    dsbs_brk_state_t st_q, st_d;
    logic [TW-1:0] tick_q, tick_d;
    logic [9:0]    cnt_q, cnt_d;
    logic          rel_q, rel_d, hold_q, hold_d, zero_q, zero_d, inh_q;
    logic [15:0]   hval_q, hval_d, rel_f;
    logic          tick;
    assign tick  = (tick_q == TW'(TICK_LEN - 1));
    assign rel_f = dir_q ? reg_q[REG_FRQ][F_HI +: 16] : reg_q[REG_FRQ][15:0];

    always_comb begin
        tick_d = tick ? '0 : tick_q + 1'b1;
        st_d   = st_q;
        cnt_d  = (tick && cnt_q != 10'h3ff) ? cnt_q + 10'h001 : cnt_q;
        rel_d  = rel_q;
        hold_d = 1'b0;
        hval_d = hval_q;
        zero_d = 1'b0;
        case (st_q)
            BRK_IDLE: begin
                rel_d = 1'b0;
                if (run_q) st_d = BRK_ACCEL;
            end
            BRK_ACCEL: begin
                if (!run_q) st_d = BRK_IDLE;
                else if (output_frequency >= rel_f) begin
                    st_d = BRK_WAITI;
                    hold_d = 1'b1;
                    hval_d = rel_f;
                end
            end
            BRK_WAITI: begin
                hold_d = 1'b1;
                if (!run_q) st_d = BRK_IDLE;
                else if (motor_current >= reg_q[REG_CUR][10:0]) begin
                    rel_d = 1'b1;
                    cnt_d = 10'h000;
                    st_d  = BRK_RHOLD;
                end
            end
            BRK_RHOLD: begin
                hold_d = 1'b1;
                if (!run_q) st_d = BRK_DECEL;
                else if (cnt_q > reg_q[REG_DLY][9:0]) st_d = BRK_RUN;
            end
            BRK_RUN: if (!run_q) st_d = BRK_DECEL;
            BRK_DECEL: begin
                if (run_q) st_d = BRK_RUN;
                else if (output_frequency <= reg_q[REG_ENG][15:0]) begin
                    rel_d  = 1'b0;
                    hold_d = 1'b1;
                    hval_d = reg_q[REG_ENG][15:0];
                    cnt_d  = 10'h000;
                    st_d   = BRK_EHOLD;
                end
            end
            BRK_EHOLD: begin
                hold_d = 1'b1;
                if (cnt_q > reg_q[REG_DLY][F_HI +: 10]) begin
                    zero_d = 1'b1;
                    st_d   = BRK_ZERO;
                end
            end
            BRK_ZERO: begin
                zero_d = !run_q;
                if (run_q) st_d = BRK_ACCEL;
            end
            default: st_d = BRK_IDLE;
        endcase
        if (!brk_active) begin
            st_d   = BRK_IDLE;
            rel_d  = 1'b0;
            hold_d = 1'b0;
            zero_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q <= BRK_IDLE;
            {tick_q, cnt_q, rel_q, hold_q, hval_q, zero_q, inh_q} <= '0;
        end else begin
            st_q   <= st_d;
            tick_q <= tick_d;
            cnt_q  <= cnt_d;
            rel_q  <= rel_d;
            hold_q <= hold_d;
            hval_q <= hval_d;
            zero_q <= zero_d;
            inh_q  <= brk_active;
        end
    end
    assign brake_release          = rel_q;
    assign freq_hold              = hold_q;
    assign freq_hold_value        = hval_q;
    assign force_zero             = zero_q;
    assign start_dc_dwell_inhibit = inh_q;

    // Live status; a read shows the state of the cycle before.
    assign status_w = {16'h0000, 1'b0, st_q, rel_q, brk_active, pb_q, sd_q,
                       rstop_q, sel_on, spd_q[1:0], 1'b0, run_q, dir_q, 1'b0};
endmodule

/* File: dsbs_sva.sv */
// Checker on the bus handshake and control outputs.
`timescale 1ns/1ps
module dsbs_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic accelerating,
    input wire logic decelerating,
    input wire logic dc_link_high,
    input wire logic stall_accel_en,
    input wire logic stall_const_en,
    input wire logic stall_decel_en,
    input wire logic power_brake_en,
    input wire logic decel_slope_reduce,
    input wire logic brake_release,
    input wire logic freq_hold,
    input wire logic force_zero,
    input wire logic start_dc_dwell_inhibit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // One wait cycle per access, then a one-cycle answer.
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    stall_acc_a: assert property (stall_accel_en |-> $past(accelerating))
        else $error("stray accel stall");
    stall_const_a: assert property (stall_const_en |-> $past(!accelerating && !decelerating))
        else $error("stray constant stall");
    brake_wins_a: assert property (!(stall_decel_en && power_brake_en))
        else $error("decel stall with power braking");
    pb_decel_a: assert property (power_brake_en |-> $past(decelerating))
        else $error("stray power braking");
    slope_ease_a: assert property (decel_slope_reduce |-> $past(dc_link_high && decelerating))
        else $error("stray slope easing");
    rel_hold_a: assert property ($rose(brake_release) |-> freq_hold)
        else $error("release without hold");
    inhibit_on_a: assert property (brake_release |-> start_dc_dwell_inhibit)
        else $error("start not inhibited");
    engage_hold_a: assert property ($fell(brake_release) |-> freq_hold)
        else $error("engage without hold");
    zero_engaged_a: assert property (force_zero |-> !brake_release)
        else $error("zero while released");
endmodule

bind dsbs_top dsbs_sva chk (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
    .accelerating, .decelerating, .dc_link_high, .stall_accel_en, .stall_const_en,
    .stall_decel_en, .power_brake_en, .decel_slope_reduce, .brake_release, .freq_hold,
    .force_zero, .start_dc_dwell_inhibit);

/* File: dsbs_motor_model.sv */
// Motor and load model that ramps the output frequency.
`timescale 1ns/1ps
module dsbs_motor_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        slow,
    input  wire logic        run_command,
    input  wire logic        freq_hold,
    input  wire logic [15:0] freq_hold_value,
    input  wire logic        force_zero,
    input  wire logic [15:0] target,
    input  wire logic [10:0] load_current,
    output logic      [15:0] output_frequency,
    output logic      [10:0] motor_current
);
    logic [1:0] div_q;

    // One step a cycle, or one in four when slow, like a heavy load.
    always_ff @(posedge clk) begin
        div_q <= reset_n ? div_q + 2'h1 : 2'h0;
        if (!reset_n || force_zero) begin
            output_frequency <= 16'h0000;
        end else if (freq_hold) begin
            output_frequency <= freq_hold_value;
        end else if (!slow || div_q == 2'h0) begin
            if (run_command && output_frequency < target)
                output_frequency <= output_frequency + 16'h0001;
            else if (!run_command && output_frequency != 16'h0000)
                output_frequency <= output_frequency - 16'h0001;
        end
    end

    // Current flows only while the drive commands a run.
    assign motor_current = run_command ? load_current : 11'h000;
endmodule

/* File: dsbs_tb_top.sv */
// Testbench for the drive source and brake block.
`timescale 1ns/1ps
module dsbs_tb_top;
    import dsbs_pkg::*;
    logic [6:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, speed_source;
    logic [7:0]  input_terminals;
    logic [15:0] output_frequency, freq_hold_value, target;
    logic [10:0] motor_current, load_current;
    logic clk, reset_n, avs_read, avs_write, avs_waitrequest, keypad_run, keypad_dir_ccw;
    logic forward_run_input, reverse_run_input, link_run, link_dir_ccw, accelerating;
    logic decelerating, dc_link_high, run_command, run_dir_ccw, ramp_stop, stall_accel_en;
    logic stall_const_en, stall_decel_en, power_brake_en, decel_slope_reduce, brake_release;
    logic freq_hold, force_zero, start_dc_dwell_inhibit, slow;
    int n_mismatch = 0;
    int num_checks = 0;

    dsbs_top #(.TICK_LEN(4)) uut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .input_terminals,
        .keypad_run, .keypad_dir_ccw, .forward_run_input, .reverse_run_input, .link_run,
        .link_dir_ccw, .output_frequency, .motor_current, .accelerating, .decelerating,
        .dc_link_high, .run_command, .run_dir_ccw, .speed_source, .ramp_stop, .stall_accel_en,
        .stall_const_en, .stall_decel_en, .power_brake_en, .decel_slope_reduce, .brake_release,
        .freq_hold, .freq_hold_value, .force_zero, .start_dc_dwell_inhibit);
    dsbs_motor_model motor (.clk, .reset_n, .slow, .run_command, .freq_hold, .freq_hold_value,
        .force_zero, .target, .load_current, .output_frequency, .motor_current);

    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus access, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    // Bounded wait on hold (0), release (1) or zero (2); gives the cycles taken.
    task automatic wait_for(input int s, input logic v, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((s == 0 ? freq_hold : s == 1 ? brake_release : force_zero) !== v && n < 2000);
        if (n >= 2000) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic sources();
        int c;
        wr(7'h28, 32'h16);
        for (int k = 0; k < 8; k++) begin
            c = k % 4;
            wr(7'h00, 32'h8100 | (k << 4) | c);
            input_terminals <= 8'h04;
            keypad_run <= (c == 0);
            forward_run_input <= (c == 1 || c == 2);
            reverse_run_input <= (c == 2);
            link_run <= (c == 3);
            link_dir_ccw <= (c == 3);
            repeat (3) @(posedge clk);
            chk(run_command, 1'b1);
            chk(run_dir_ccw, c >= 2);
            chk(speed_source, k);
        end
        input_terminals <= 8'h08;
        repeat (3) @(posedge clk);
        chk(speed_source, 4'h8);
        chk(run_command, 1'b0);
    endtask

    // Leaving alternate for a link-run primary set ramps down.
    task automatic link_loss();
        wr(7'h00, 32'h0301);
        link_run <= 1'b0;
        forward_run_input <= 1'b1;
        input_terminals <= 8'h04;
        repeat (3) @(posedge clk);
        chk(run_command, 1'b1);
        input_terminals <= 8'h00;
        repeat (3) @(posedge clk);
        chk(ramp_stop, 1'b1);
        chk(run_command, 1'b0);
        link_run <= 1'b1;
        repeat (3) @(posedge clk);
        chk(ramp_stop, 1'b0);
        link_run <= 1'b0;
        forward_run_input <= 1'b0;
        wr(7'h00, RST_SRC);
    endtask

    task automatic protection();
        wr(7'h04, 32'h140);
        rdchk(7'h04, 32'h40);
        wr(7'h04, 32'h140);
        rdchk(7'h04, 32'h140);
        for (int i = 0; i < 8; i++) begin
            wr(7'h04, (i[2] ? 32'h3 : 32'h0) | 32'h70);
            accelerating <= i[0];
            decelerating <= i[1];
            dc_link_high <= 1'b1;
            repeat (3) @(posedge clk);
            chk(stall_accel_en, i[0]);
            chk(stall_const_en, !i[0] & !i[1]);
            chk(stall_decel_en, i[1] & !i[2]);
            chk(power_brake_en, i[1] & i[2]);
            chk(decel_slope_reduce, i[1] & i[2]);
        end
        accelerating <= 1'b0;
        decelerating <= 1'b0;
    endtask

    // One run and stop through the brake; delays are 3 ticks of 4 cycles.
    task automatic brake_run(input logic ccw, input logic [15:0] rel);
        int n;
        load_current <= 11'h000;
        forward_run_input <= !ccw;
        reverse_run_input <= ccw;
        wait_for(0, 1'b1, n);
        chk(freq_hold_value, rel);
        repeat (20) @(posedge clk);
        chk(brake_release, 1'b0);
        load_current <= 11'h1f4;
        wait_for(1, 1'b1, n);
        chk(n <= 4, 1'b1);
        chk(start_dc_dwell_inhibit, 1'b1);
        wait_for(0, 1'b0, n);
        chk(n >= 11 && n <= 21, 1'b1);
        forward_run_input <= 1'b0;
        reverse_run_input <= 1'b0;
        wait_for(1, 1'b0, n);
        chk(freq_hold_value, 16'h00c8);
        chk(output_frequency <= 16'h00c8, 1'b1);
        wait_for(2, 1'b1, n);
        chk(n >= 11 && n <= 21, 1'b1);
        repeat (3) @(posedge clk);
        chk(output_frequency, 16'h0);
    endtask

    task automatic brake_all();
        rdchk(7'h0c, 32'h0);
        wr(7'h08, 32'h1300);
        rdchk(7'h0c, RST_CUR);
        wr(7'h10, 32'h0003_0003);
        wr(7'h14, 32'h0096_0064);
        brake_run(1'b0, 16'h0064);
        slow <= 1'b1;
        brake_run(1'b1, 16'h0096);
        slow <= 1'b0;
        wr(7'h08, 32'h1301);
        forward_run_input <= 1'b1;
        repeat (400) @(posedge clk);
        chk(brake_release, 1'b0);
        chk(freq_hold, 1'b0);
        chk(start_dc_dwell_inhibit, 1'b0);
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        reset_n = 1'b0;
        {avs_read, avs_write, keypad_run, keypad_dir_ccw, forward_run_input, slow} = 6'h00;
        {reverse_run_input, link_run, link_dir_ccw, accelerating, decelerating} = 5'h00;
        dc_link_high = 1'b0;
        avs_address = 7'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        input_terminals = 8'h00;
        target = 16'h012c;
        load_current = 11'h000;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(7'h40, 32'h0);
        rdchk(7'h08, RST_CTRL);
        sources();
        link_loss();
        protection();
        brake_all();
        give_verdict();
    end
endmodule
